// file: common/mid_defs.svh
// Constants for the 14-bit instruction decoder: opcodes, fixed words, addresses, timing.
// Assumes a single clock at 10 MHz used as the oscillator period and one include per unit.
// Contract
// - Byte group 00: op, dest, file address
// - Byte OR and AND affect zero only
// - Decrement; decrement-skip-zero takes one or two
// - Increment; increment-skip-zero takes one or two
// - Rotate left through carry, carry only
// - Rotate right through carry, carry only
// - Bit group 01: clear, set, skip-clear
// - Skip-if-set: one or two, no flags
// - Branches and true tests add NOP cycle
// - Literal OR, AND, add into W
// - Load literal one cycle; return-with-literal two
// - Subtract W from literal, sets C DC Z
// - Literal XOR into W, zero only
// - Fixed word clears watchdog, sets TO PD
// - Fixed word enters standby, sets TO PD
// - Interrupt return two cycles, no flags
// - Plain return two cycles, no flags
// - Port read-modify-write sources pin levels
// - Timer write clears assigned prescaler; the decoder does not clear it for a move from W to file
// - Dest bit zero to W, one to file
// - File field spans whole register range
// - Instruction cycle is four oscillator periods
`ifndef MID_DEFS_SVH
`define MID_DEFS_SVH

`define MID_GRP_BYTE        2'h0
`define MID_GRP_BIT         2'h1
`define MID_GRP_BRANCH      2'h2
`define MID_GRP_LIT         2'h3

`define MID_BOP_MOVE_CTRL   4'h0
`define MID_BOP_CLEAR       4'h1
`define MID_BOP_SUB         4'h2
`define MID_BOP_DEC         4'h3
`define MID_BOP_OR          4'h4
`define MID_BOP_AND         4'h5
`define MID_BOP_XOR         4'h6
`define MID_BOP_ADD         4'h7
`define MID_BOP_MOVE        4'h8
`define MID_BOP_COMP        4'h9
`define MID_BOP_INC         4'hA
`define MID_BOP_DEC_SKIP    4'hB
`define MID_BOP_ROT_RIGHT   4'hC
`define MID_BOP_ROT_LEFT    4'hD
`define MID_BOP_SWAP        4'hE
`define MID_BOP_INC_SKIP    4'hF

`define MID_BIT_CLEAR       2'h0
`define MID_BIT_SET         2'h1
`define MID_BIT_SKIP_CLR    2'h2
`define MID_BIT_SKIP_SET    2'h3

`define MID_LIT_LOAD_HI     2'h0
`define MID_LIT_RET_HI      2'h1
`define MID_LIT_SUB_HI      3'h6
`define MID_LIT_ADD_HI      3'h7
`define MID_LIT_OR          4'h8
`define MID_LIT_AND         4'h9
`define MID_LIT_XOR         4'hA

`define MID_LOW_RETURN      7'h08
`define MID_LOW_INT_RET     7'h09
`define MID_LOW_STANDBY     7'h63
`define MID_LOW_WDT_CLEAR   7'h64
`define MID_NOP_LOW         5'h00

`define MID_AFFECT_NONE     5'h00
`define MID_AFFECT_Z        5'h04
`define MID_AFFECT_C        5'h10
`define MID_AFFECT_CDZ      5'h1C
`define MID_AFFECT_TP       5'h03

`define MID_TIMER_ZERO_ADDR 7'h01
`define MID_PORT_FIRST      7'h05
`define MID_PORT_LAST       7'h09

`define MID_PHASE_FIRST     2'h0
`define MID_PHASE_PRE       2'h2
`define MID_PHASE_LAST      2'h3
`define MID_PHASE_STEP      2'h1

`endif

// file: common/mid_pkg.sv
// Types shared by the instruction decoder: operations, fields, control word, states.
// Assumes mid_defs.svh for the numeric constants.
package mid_pkg;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_ADD_W_TO_FILE = 6'h01, OP_AND_W_WITH_FILE = 6'h02, OP_CLEAR_FILE = 6'h03,
    OP_CLEAR_W = 6'h04, OP_COMPLEMENT = 6'h05, OP_DECREMENT_FILE = 6'h06, OP_DECREMENT_SKIP_ZERO = 6'h07,
    OP_INCREMENT_FILE = 6'h08, OP_INCREMENT_SKIP_ZERO = 6'h09, OP_OR_W_WITH_FILE = 6'h0A, OP_MOVE_FILE = 6'h0B,
    OP_MOVE_W_TO_FILE = 6'h0C, OP_ROTATE_LEFT_CARRY = 6'h0D, OP_ROTATE_RIGHT_CARRY = 6'h0E,
    OP_SUB_W_FROM_FILE = 6'h0F, OP_SWAP_NIBBLES = 6'h10, OP_XOR_W_WITH_FILE = 6'h11, OP_BIT_CLEAR = 6'h12,
    OP_BIT_SET = 6'h13, OP_SKIP_IF_BIT_CLEAR = 6'h14, OP_SKIP_IF_BIT_SET = 6'h15, OP_ADD_LITERAL = 6'h16,
    OP_AND_LITERAL = 6'h17, OP_CALL = 6'h18, OP_WATCHDOG_CLEAR = 6'h19, OP_JUMP = 6'h1A,
    OP_OR_LITERAL = 6'h1B, OP_LOAD_LITERAL = 6'h1C, OP_INTERRUPT_RETURN = 6'h1D,
    OP_RETURN_WITH_LITERAL = 6'h1E, OP_RETURN = 6'h1F, OP_STANDBY = 6'h20, OP_SUB_FROM_LITERAL = 6'h21,
    OP_XOR_LITERAL = 6'h22
  } mid_op_t;

  typedef enum logic {
    ST_EXEC  = 1'h0,
    ST_FLUSH = 1'h1
  } mid_state_t;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
    logic timeout_flag;
    logic powerdown_flag;
  } mid_flags_t;

  typedef struct packed {
    logic [1:0]  group;
    logic [3:0]  byte_op;
    logic        dest;
    logic [6:0]  file_addr;
    logic [1:0]  bit_op;
    logic [2:0]  bit_index;
    logic [3:0]  lit_sel;
    logic [7:0]  literal;
    logic        branch_jump;
    logic [10:0] target;
  } mid_fields_t;

  typedef struct packed {
    mid_op_t     op;
    logic        dest_file;
    logic [6:0]  file_addr;
    logic [2:0]  bit_index;
    logic [7:0]  literal;
    logic [10:0] target;
    mid_flags_t  affects;
    logic        two_cycle;
    logic        skip_test;
    logic        reads_file;
    logic        writes_file;
  } mid_ctrl_t;

endpackage

// file: rtl/mid_decoder.sv
// Instruction decoder: turns fetched 14-bit words into control for the core datapath.
// Assumes program memory presents the next word by the last period of each cycle, and
// the datapath reports result_zero and tested_bit during the executing cycle.
`include "mid_defs.svh"

module mid_decoder (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic [13:0]          instr_word,
  input  wire logic                 result_zero,
  input  wire logic                 tested_bit,
  input  wire logic                 prescaler_on_timer,
  output mid_pkg::mid_ctrl_t        ctrl,
  output logic                      flush_cycle,
  output logic      [1:0]           cycle_phase,
  output logic                      cycle_start,
  output logic                      pin_source,
  output logic                      prescaler_clear,
  output logic                      illegal_op
);

  mid_pkg::mid_fields_t fld;
  mid_pkg::mid_ctrl_t   dec;
  mid_pkg::mid_ctrl_t   next_ctrl;
  mid_pkg::mid_state_t  state;
  mid_pkg::mid_state_t  next_state;
  logic                 dec_illegal;
  logic                 next_flush;
  logic                 next_pin_source;
  logic                 next_prescaler_clear;
  logic                 next_illegal;
  logic                 skip_hit;
  logic                 take;
  logic                 last_phase;
  logic                 latch;
  logic                 port_hit;
  logic                 timer_hit;

  mid_field_split u_split (
    .word   (instr_word),
    .fields (fld)
  );

  mid_phase_counter u_phase (
    .clock (clock),
    .nrst  (nrst),
    .phase (cycle_phase),
    .start (cycle_start)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Word decode
  always_comb begin
    dec             = '0;
    dec_illegal     = 1'b0;
    dec.file_addr   = fld.file_addr;
    dec.bit_index   = fld.bit_index;
    dec.literal     = fld.literal;
    dec.target      = fld.target;
    dec.dest_file   = fld.dest;
    if (fld.group == `MID_GRP_BYTE) begin
      dec.reads_file  = 1'b1;
      dec.writes_file = fld.dest;
      case (fld.byte_op)
        `MID_BOP_MOVE_CTRL: begin
          dec.reads_file  = 1'b0;
          if (fld.dest) begin
            dec.op = mid_pkg::OP_MOVE_W_TO_FILE;
          end else if (fld.file_addr == `MID_LOW_RETURN) begin
            dec.op        = mid_pkg::OP_RETURN;
            dec.two_cycle = 1'b1;
          end else if (fld.file_addr == `MID_LOW_INT_RET) begin
            dec.op        = mid_pkg::OP_INTERRUPT_RETURN;
            dec.two_cycle = 1'b1;
          end else if (fld.file_addr == `MID_LOW_WDT_CLEAR) begin
            dec.op      = mid_pkg::OP_WATCHDOG_CLEAR;
            dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_TP);
          end else if (fld.file_addr == `MID_LOW_STANDBY) begin
            dec.op      = mid_pkg::OP_STANDBY;
            dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_TP);
          end else if (fld.file_addr[4:0] == `MID_NOP_LOW) begin
            dec.op = mid_pkg::OP_NOP;
          end else begin
            dec_illegal = 1'b1;
          end
        end
        `MID_BOP_CLEAR: begin
          dec.reads_file = 1'b0;
          dec.op         = fld.dest ? mid_pkg::OP_CLEAR_FILE : mid_pkg::OP_CLEAR_W;
          dec.affects    = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
        end
        `MID_BOP_SUB: begin
          dec.op      = mid_pkg::OP_SUB_W_FROM_FILE;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_CDZ);
        end
        `MID_BOP_DEC: begin
          dec.op      = mid_pkg::OP_DECREMENT_FILE;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
        end
        `MID_BOP_OR: begin
          dec.op      = mid_pkg::OP_OR_W_WITH_FILE;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
        end
        `MID_BOP_AND: begin
          dec.op      = mid_pkg::OP_AND_W_WITH_FILE;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
        end
        `MID_BOP_XOR: begin
          dec.op      = mid_pkg::OP_XOR_W_WITH_FILE;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
        end
        `MID_BOP_ADD: begin
          dec.op      = mid_pkg::OP_ADD_W_TO_FILE;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_CDZ);
        end
        `MID_BOP_MOVE: begin
          dec.op      = mid_pkg::OP_MOVE_FILE;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
        end
        `MID_BOP_COMP: begin
          dec.op      = mid_pkg::OP_COMPLEMENT;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
        end
        `MID_BOP_INC: begin
          dec.op      = mid_pkg::OP_INCREMENT_FILE;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
        end
        `MID_BOP_DEC_SKIP: begin
          dec.op        = mid_pkg::OP_DECREMENT_SKIP_ZERO;
          dec.skip_test = 1'b1;
        end
        `MID_BOP_ROT_RIGHT: begin
          dec.op      = mid_pkg::OP_ROTATE_RIGHT_CARRY;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_C);
        end
        `MID_BOP_ROT_LEFT: begin
          dec.op      = mid_pkg::OP_ROTATE_LEFT_CARRY;
          dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_C);
        end
        `MID_BOP_SWAP: begin
          dec.op = mid_pkg::OP_SWAP_NIBBLES;
        end
        default: begin
          dec.op        = mid_pkg::OP_INCREMENT_SKIP_ZERO;
          dec.skip_test = 1'b1;
        end
      endcase
    end else if (fld.group == `MID_GRP_BIT) begin
      dec.reads_file = 1'b1;
      dec.dest_file  = 1'b1;
      case (fld.bit_op)
        `MID_BIT_CLEAR: begin
          dec.op          = mid_pkg::OP_BIT_CLEAR;
          dec.writes_file = 1'b1;
        end
        `MID_BIT_SET: begin
          dec.op          = mid_pkg::OP_BIT_SET;
          dec.writes_file = 1'b1;
        end
        `MID_BIT_SKIP_CLR: begin
          dec.op        = mid_pkg::OP_SKIP_IF_BIT_CLEAR;
          dec.skip_test = 1'b1;
        end
        default: begin
          dec.op        = mid_pkg::OP_SKIP_IF_BIT_SET;
          dec.skip_test = 1'b1;
        end
      endcase
    end else if (fld.group == `MID_GRP_BRANCH) begin
      dec.two_cycle = 1'b1;
      dec.op        = fld.branch_jump ? mid_pkg::OP_JUMP : mid_pkg::OP_CALL;
    end else begin
      if (fld.lit_sel[3:2] == `MID_LIT_LOAD_HI) begin
        dec.op = mid_pkg::OP_LOAD_LITERAL;
      end else if (fld.lit_sel[3:2] == `MID_LIT_RET_HI) begin
        dec.op        = mid_pkg::OP_RETURN_WITH_LITERAL;
        dec.two_cycle = 1'b1;
      end else if (fld.lit_sel[3:1] == `MID_LIT_ADD_HI) begin
        dec.op      = mid_pkg::OP_ADD_LITERAL;
        dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_CDZ);
      end else if (fld.lit_sel[3:1] == `MID_LIT_SUB_HI) begin
        dec.op      = mid_pkg::OP_SUB_FROM_LITERAL;
        dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_CDZ);
      end else if (fld.lit_sel == `MID_LIT_OR) begin
        dec.op      = mid_pkg::OP_OR_LITERAL;
        dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
      end else if (fld.lit_sel == `MID_LIT_AND) begin
        dec.op      = mid_pkg::OP_AND_LITERAL;
        dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
      end else if (fld.lit_sel == `MID_LIT_XOR) begin
        dec.op      = mid_pkg::OP_XOR_LITERAL;
        dec.affects = mid_pkg::mid_flags_t'(`MID_AFFECT_Z);
      end else begin
        dec_illegal = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Skip and branch sequencing
  always_comb begin
    skip_hit = 1'b0;
    case (ctrl.op)
      mid_pkg::OP_DECREMENT_SKIP_ZERO: skip_hit = result_zero;
      mid_pkg::OP_INCREMENT_SKIP_ZERO: skip_hit = result_zero;
      mid_pkg::OP_SKIP_IF_BIT_CLEAR:   skip_hit = !tested_bit;
      mid_pkg::OP_SKIP_IF_BIT_SET:     skip_hit = tested_bit;
      default:                         skip_hit = 1'b0;
    endcase
  end

  assign take       = (state == mid_pkg::ST_EXEC) && (ctrl.two_cycle || (ctrl.skip_test && skip_hit));
  assign last_phase = (cycle_phase == `MID_PHASE_LAST);
  assign latch      = last_phase && !take;
  assign port_hit   = (dec.file_addr >= `MID_PORT_FIRST) && (dec.file_addr <= `MID_PORT_LAST);
  assign timer_hit  = (ctrl.file_addr == `MID_TIMER_ZERO_ADDR);

  always_comb begin
    next_state           = state;
    next_ctrl            = ctrl;
    next_flush           = flush_cycle;
    next_pin_source      = pin_source;
    next_illegal         = illegal_op;
    next_prescaler_clear = (cycle_phase == `MID_PHASE_PRE) && (state == mid_pkg::ST_EXEC) && timer_hit &&
                           prescaler_on_timer && ctrl.writes_file &&
                           (ctrl.op != mid_pkg::OP_MOVE_W_TO_FILE);
    if (last_phase) begin
      if (take) begin
        next_state      = mid_pkg::ST_FLUSH;
        next_ctrl       = '0;
        next_flush      = 1'b1;
        next_pin_source = 1'b0;
        next_illegal    = 1'b0;
      end else begin
        next_state      = mid_pkg::ST_EXEC;
        next_ctrl       = dec;
        next_flush      = 1'b0;
        next_pin_source = dec.reads_file && dec.writes_file && port_hit;
        next_illegal    = dec_illegal;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state           <= mid_pkg::ST_EXEC;
      ctrl            <= '0;
      flush_cycle     <= 1'b0;
      pin_source      <= 1'b0;
      prescaler_clear <= 1'b0;
      illegal_op      <= 1'b0;
    end else begin
      state           <= next_state;
      ctrl            <= next_ctrl;
      flush_cycle     <= next_flush;
      pin_source      <= next_pin_source;
      prescaler_clear <= next_prescaler_clear;
      illegal_op      <= next_illegal;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_add_decode: assert property (@(posedge clock) disable iff (!nrst)
    (latch && instr_word[13:8] == 6'h07) |=> (ctrl.op == mid_pkg::OP_ADD_W_TO_FILE) &&
      (ctrl.affects == mid_pkg::mid_flags_t'(`MID_AFFECT_CDZ)) && (ctrl.writes_file == $past(instr_word[7])))
    else $error("add decode wrong");

  a_or_zero_only: assert property (@(posedge clock) disable iff (!nrst)
    (latch && instr_word[13:8] == 6'h04) |=> (ctrl.op == mid_pkg::OP_OR_W_WITH_FILE) &&
      (ctrl.affects == mid_pkg::mid_flags_t'(`MID_AFFECT_Z)) && !ctrl.two_cycle)
    else $error("or decode wrong");

  a_dec_skip_taken: assert property (@(posedge clock) disable iff (!nrst)
    (last_phase && state == mid_pkg::ST_EXEC && ctrl.op == mid_pkg::OP_DECREMENT_SKIP_ZERO && result_zero)
      |=> flush_cycle [*4] ##1 !flush_cycle)
    else $error("decrement skip not taken");

  a_inc_no_skip: assert property (@(posedge clock) disable iff (!nrst)
    (last_phase && ctrl.op == mid_pkg::OP_INCREMENT_SKIP_ZERO && !result_zero) |=> !flush_cycle)
    else $error("increment skip taken wrongly");

  a_rotate_carry: assert property (@(posedge clock) disable iff (!nrst)
    (ctrl.op == mid_pkg::OP_ROTATE_LEFT_CARRY || ctrl.op == mid_pkg::OP_ROTATE_RIGHT_CARRY)
      |-> (ctrl.affects == mid_pkg::mid_flags_t'(`MID_AFFECT_C)))
    else $error("rotate flags wrong");

  a_bit_skip_clr: assert property (@(posedge clock) disable iff (!nrst)
    (last_phase && ctrl.op == mid_pkg::OP_SKIP_IF_BIT_CLEAR) |=> (flush_cycle == !$past(tested_bit)))
    else $error("skip on clear wrong");

  a_skip_set_flags: assert property (@(posedge clock) disable iff (!nrst)
    (ctrl.op == mid_pkg::OP_SKIP_IF_BIT_SET) |-> (ctrl.affects == '0) && ctrl.skip_test)
    else $error("skip on set flags wrong");

  a_branch_nop: assert property (@(posedge clock) disable iff (!nrst)
    (last_phase && state == mid_pkg::ST_EXEC && ctrl.two_cycle)
      |=> (flush_cycle && ctrl.op == mid_pkg::OP_NOP) [*4] ##1 !flush_cycle)
    else $error("branch nop cycle wrong");

  a_wdt_clear: assert property (@(posedge clock) disable iff (!nrst)
    (latch && instr_word == 14'h0064) |=> (ctrl.op == mid_pkg::OP_WATCHDOG_CLEAR) &&
      (ctrl.affects == mid_pkg::mid_flags_t'(`MID_AFFECT_TP)))
    else $error("watchdog clear decode wrong");

  a_int_return: assert property (@(posedge clock) disable iff (!nrst)
    (latch && instr_word == 14'h0009) |=> (ctrl.op == mid_pkg::OP_INTERRUPT_RETURN) && ctrl.two_cycle &&
      (ctrl.affects == '0))
    else $error("interrupt return decode wrong");

  a_pin_source: assert property (@(posedge clock) disable iff (!nrst)
    pin_source |-> ctrl.reads_file && ctrl.writes_file && (ctrl.file_addr >= `MID_PORT_FIRST) &&
      (ctrl.file_addr <= `MID_PORT_LAST))
    else $error("pin source outside port");

  a_prescaler_clr: assert property (@(posedge clock) disable iff (!nrst)
    prescaler_clear |-> (cycle_phase == `MID_PHASE_LAST) && (ctrl.file_addr == `MID_TIMER_ZERO_ADDR) &&
      ctrl.writes_file && $past(prescaler_on_timer))
    else $error("prescaler clear wrong");

  a_cycle_four: assert property (@(posedge clock) disable iff (!nrst)
    cycle_start |=> !cycle_start [*3] ##1 cycle_start)
    else $error("cycle not four periods");

  a_load_dont_care: assert property (@(posedge clock) disable iff (!nrst)
    (latch && instr_word[13:10] == 4'hC) |=> (ctrl.op == mid_pkg::OP_LOAD_LITERAL) &&
      (ctrl.literal == $past(instr_word[7:0])))
    else $error("load literal decode wrong");

endmodule // mid_decoder

// file: rtl/mid_field_split.sv
// Splits a 14-bit instruction word into its operand fields.
// Assumes the word is stable from program memory on the decoder clock.
module mid_field_split (
  input  wire logic [13:0]          word,
  output mid_pkg::mid_fields_t      fields
);

  always_comb begin
    fields             = '0;
    fields.group       = word[13:12];
    fields.byte_op     = word[11:8];
    fields.dest        = word[7];
    fields.file_addr   = word[6:0];
    fields.bit_op      = word[11:10];
    fields.bit_index   = word[9:7];
    fields.lit_sel     = word[11:8];
    fields.literal     = word[7:0];
    fields.branch_jump = word[11];
    fields.target      = word[10:0];
  end

endmodule // mid_field_split

// file: rtl/mid_phase_counter.sv
// Counts the four oscillator periods of one instruction cycle.
// Assumes the clock is the oscillator and a synchronous active-low reset.
`include "mid_defs.svh"

module mid_phase_counter (
  input  wire logic       clock,
  input  wire logic       nrst,
  output logic      [1:0] phase,
  output logic            start
);

  logic [1:0] next_phase;
  logic       next_start;

  always_comb begin
    next_phase = phase + `MID_PHASE_STEP;
    next_start = (phase == `MID_PHASE_LAST);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      phase <= `MID_PHASE_LAST;
      start <= 1'b0;
    end else begin
      phase <= next_phase;
      start <= next_start;
    end
  end

endmodule // mid_phase_counter

// file: tb/mid_decoder_tb_top.sv
// Testbench for the instruction decoder: a table of words with their expected decode.
// Assumes the program memory model steps one word per instruction cycle.
module mid_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [13:0] w;
    logic [5:0]  op;
    logic [4:0]  aff;
    logic [2:0]  f;
  } mid_row_t;
  logic                clock;
  logic                nrst;
  logic                cond;
  logic                pot;
  logic                wr_en;
  logic [5:0]          wr_addr;
  logic [13:0]         wr_data;
  logic [13:0]         word;
  mid_pkg::mid_ctrl_t  ctrl;
  logic                flush_cycle;
  logic [1:0]          cycle_phase;
  logic                cycle_start;
  logic                pin_source;
  logic                prescaler_clear;
  logic                illegal_op;
  int                  fail_count;
  int                  num_checks;
  mid_row_t            rows [45] = '{
    '{14'h0785,6'h01,5'h1C,3'h2}, '{14'h0205,6'h0F,5'h1C,3'h0}, '{14'h0681,6'h11,5'h04,3'h1},
    '{14'h047F,6'h0A,5'h04,3'h0}, '{14'h0580,6'h02,5'h04,3'h0}, '{14'h0380,6'h06,5'h04,3'h0},
    '{14'h0A80,6'h08,5'h04,3'h0}, '{14'h0D80,6'h0D,5'h10,3'h0}, '{14'h0C80,6'h0E,5'h10,3'h0},
    '{14'h1009,6'h12,5'h00,3'h2}, '{14'h1781,6'h13,5'h00,3'h1}, '{14'h0B80,6'h07,5'h00,3'h4},
    '{14'h0000,6'h00,5'h00,3'h0}, '{14'h0F80,6'h09,5'h00,3'h4}, '{14'h0000,6'h00,5'h00,3'h0},
    '{14'h1800,6'h14,5'h00,3'h0}, '{14'h1C00,6'h15,5'h00,3'h4}, '{14'h0000,6'h00,5'h00,3'h0},
    '{14'h2000,6'h18,5'h00,3'h4}, '{14'h0000,6'h00,5'h00,3'h0}, '{14'h2FFF,6'h1A,5'h00,3'h4},
    '{14'h0000,6'h00,5'h00,3'h0}, '{14'h3855,6'h1B,5'h04,3'h0}, '{14'h3955,6'h17,5'h04,3'h0},
    '{14'h3E55,6'h16,5'h1C,3'h0}, '{14'h3F55,6'h16,5'h1C,3'h0}, '{14'h3000,6'h1C,5'h00,3'h0},
    '{14'h33FF,6'h1C,5'h00,3'h0}, '{14'h3400,6'h1E,5'h00,3'h4}, '{14'h0000,6'h00,5'h00,3'h0},
    '{14'h3C00,6'h21,5'h1C,3'h0}, '{14'h3A00,6'h22,5'h04,3'h0}, '{14'h0064,6'h19,5'h03,3'h0},
    '{14'h0063,6'h20,5'h03,3'h0}, '{14'h0009,6'h1D,5'h00,3'h4}, '{14'h0000,6'h00,5'h00,3'h0},
    '{14'h0008,6'h1F,5'h00,3'h4}, '{14'h0000,6'h00,5'h00,3'h0}, '{14'h3B00,6'h00,5'h00,3'h0},
    '{14'h0B81,6'h07,5'h00,3'h0}, '{14'h1800,6'h14,5'h00,3'h4}, '{14'h0000,6'h00,5'h00,3'h0},
    '{14'h1C80,6'h15,5'h00,3'h0}, '{14'h0000,6'h00,5'h00,3'h0}, '{14'h0F81,6'h09,5'h00,3'h0}};
  ////////////////////////////////////////////////////////////////////////////////////////////
  mid_prog_mem mem (.clock(clock), .nrst(nrst), .advance(cycle_start), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .word(word));
  mid_decoder dut (.clock(clock), .nrst(nrst), .instr_word(word), .result_zero(cond),
    .tested_bit(cond), .prescaler_on_timer(pot), .ctrl(ctrl), .flush_cycle(flush_cycle),
    .cycle_phase(cycle_phase), .cycle_start(cycle_start), .pin_source(pin_source),
    .prescaler_clear(prescaler_clear), .illegal_op(illegal_op));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Holds reset while loading rows lo..hi, checks the reset state, then walks one instruction cycle per row
  task automatic run(input int lo, input int hi, input logic c);
    logic fl;
    nrst = 1'b0;
    cond = c;
    pot = c;
    for (int i = lo; i <= hi; i++) begin
      @(posedge clock);
      #10 wr_en = 1'b1;
      wr_addr = 6'(i - lo);
      wr_data = rows[i].w;
    end
    @(posedge clock);
    #10 wr_en = 1'b0;
    repeat (4) @(posedge clock);
    #10 check("reset", 16'h0060, {3'h0, ctrl.op, cycle_phase, cycle_start, flush_cycle, pin_source,
      prescaler_clear, illegal_op});
    nrst = 1'b1;
    for (int i = lo; i <= hi; i++) begin
      @(posedge clock);
      #20 fl = (i > lo) ? rows[i - 1].f[2] : 1'b0;
      check("op", {10'h000, rows[i].op}, {10'h000, ctrl.op});
      check("affects", {11'h000, rows[i].aff}, {11'h000, ctrl.affects});
      check("flow", {13'h0, fl, rows[i].f[1], rows[i].w[13:8] == 6'h3B}, {13'h0, flush_cycle, pin_source, illegal_op});
      check("fields", {1'b0, rows[i].w[7:0], rows[i].w[6:0]}, {1'b0, ctrl.literal, ctrl.file_addr});
      check("target", {2'h0, rows[i].w[9:7], rows[i].w[10:0]}, {2'h0, ctrl.bit_index, ctrl.target});
      if (rows[i].w[13:12] == 2'h0) begin
        check("dest", {14'h0, rows[i].w[7], rows[i].w[7]}, {14'h0, ctrl.dest_file, ctrl.writes_file});
      end
      repeat (3) @(posedge clock);
      #20 check("prescaler", {13'h0, rows[i].f[0], 2'h3}, {13'h0, prescaler_clear, cycle_phase});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    cond = 1'b0;
    pot = 1'b0;
    wr_en = 1'b0;
    wr_addr = 6'h00;
    wr_data = 14'h0000;
    fail_count = 0;
    num_checks = 0;
    run(0, 38, 1'b1);
    run(39, 44, 1'b0);
    stop_test();
  end
endmodule // mid_decoder_tb_top

// file: tb/mid_prog_mem.sv
// Program memory model: a small writable store that steps one word per instruction cycle.
// Assumes advance is the decoder's cycle start, high for one clock in four.
module mid_prog_mem (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        advance,
  input  wire logic        wr_en,
  input  wire logic [5:0]  wr_addr,
  input  wire logic [13:0] wr_data,
  output logic      [13:0] word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] store [64];
  logic [5:0]  pc;
  always_ff @(posedge clock) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    if (!nrst) begin
      pc <= 6'h00;
    end else if (advance) begin
      pc <= pc + 6'h01;
    end
  end
  assign word = store[pc];
endmodule // mid_prog_mem
